// ### core/lacs_pkg.sv
// Constants for the load adaptive current and stall block
package lacs_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_VLOW      = 8'h04;
  localparam logic [7:0] ADDR_UPPER_VELOCITY_THRESHOLD     = 8'h08;
  localparam logic [7:0] ADDR_CUR       = 8'h0c;
  localparam logic [7:0] ADDR_DRV_STAT  = 8'h10;
  localparam logic [7:0] ADDR_RAMP_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1c;
  // Control register fields
  localparam int CTRL_MIN_LSB   = 0;   // lower_load_threshold, 4 bits
  localparam int CTRL_HYS_LSB   = 4;   // load_hysteresis_width, 4 bits
  localparam int CTRL_INC_LSB   = 8;   // current_increment_code, 2 bits
  localparam int CTRL_DEC_LSB   = 10;  // current_decrement_code, 2 bits
  localparam int CTRL_LOWER_LOAD_THRESHOLD_BIT = 12;  // Floor select: 0 half, 1 quarter
  localparam int CTRL_FILT_BIT  = 13;  // Load filter enable
  localparam int CTRL_HALT_BIT  = 14;  // halt_on_stall_enable
  localparam int CTRL_SD_BIT    = 15;  // Step and direction mode
  // Current register fields
  localparam int CUR_RUN_LSB    = 0;   // run_current_scale, 5 bits
  localparam int CUR_HOLD_LSB   = 8;   // hold_current_scale, 5 bits
  // Status bit positions
  localparam int DRV_STALL_BIT  = 24;  // Stall flag in driver_status_word
  localparam int DRV_SG_LSB     = 0;   // load_measurement field
  localparam int DRV_CS_LSB     = 16;  // regulated_current_scale field
  localparam int IRQ_STALL_BIT  = 0;
  localparam int IRQ_LOAD_BIT   = 1;
  // Arithmetic constants
  localparam int THR_SHIFT      = 5;   // Threshold fields scale by 32
  localparam int FILT_DEPTH     = 4;   // Samples averaged by the filter
  localparam int FILT_SHIFT     = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CUR_RESET  = 32'h0000_101f;
  localparam logic [22:0] UPPER_VELOCITY_THRESHOLD_RESET = 23'h7f_ffff;
  // Zero velocity wait time before restart
  localparam int ZWAIT_NS   = 1000;
  localparam int CLK_NS     = 5;
  localparam int ZWAIT_CYC  = (ZWAIT_NS + CLK_NS - 1) / CLK_NS;
  // Regulator states
  typedef enum logic [2:0] {
    LACS_IDLE = 3'b001,
    LACS_RUN  = 3'b010,
    LACS_HALT = 3'b100
  } lacs_state_e;
endpackage : lacs_pkg

// ### core/lacs_load_filter.sv
// Load measurement refresh and four-sample filter
`timescale 1ns/1ps
`default_nettype none
module lacs_load_filter
  import lacs_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  // Raw measurement
  input  wire logic       step_i,
  input  wire logic [9:0] raw_load_i,
  input  wire logic       filt_en_i,
  // Result
  output logic [9:0]      load_o,
  output logic            load_vld_o
);
  logic [11:0] sum_q;
  logic [1:0]  cnt_q;

  // Raw each full step, or mean of four when filtered
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sum_q      <= 12'h000;
      cnt_q      <= 2'h0;
      load_o     <= 10'h3ff;
      load_vld_o <= 1'b0;
    end else begin
      load_vld_o <= 1'b0;
      if (step_i) begin
        if (!filt_en_i) begin
          load_o     <= raw_load_i;
          load_vld_o <= 1'b1;
          cnt_q      <= 2'h0;
          sum_q      <= 12'h000;
        end else if (cnt_q == 2'(FILT_DEPTH - 1)) begin
          load_o     <= 10'((sum_q + {2'h0, raw_load_i}) >> FILT_SHIFT);
          load_vld_o <= 1'b1;
          cnt_q      <= 2'h0;
          sum_q      <= 12'h000;
        end else begin
          sum_q <= sum_q + {2'h0, raw_load_i};
          cnt_q <= cnt_q + 2'h1;
        end
      end
    end
  end
endmodule : lacs_load_filter
`default_nettype wire

// ### core/lacs_cur_reg.sv
// Current scale up and down regulator with saturation
`timescale 1ns/1ps
`default_nettype none
module lacs_cur_reg
  import lacs_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  // Control
  input  wire logic       active_i,
  input  wire logic       sample_i,
  input  wire logic [9:0] load_i,
  input  wire logic [3:0] lo_field_i,
  input  wire logic [3:0] hys_field_i,
  input  wire logic [1:0] inc_code_i,
  input  wire logic [1:0] dec_code_i,
  input  wire logic       quarter_i,
  input  wire logic [4:0] run_i,
  // Result
  output logic [4:0]      scale_o
);
  logic [10:0] lo_thr;
  logic [10:0] hi_thr;
  logic [5:0]  floor_v;
  logic [5:0]  step_v;
  logic [5:0]  up_v;
  logic [5:0]  dec_need;
  logic [5:0]  dec_cnt_q;

  // Thresholds and limits
  always_comb begin
    lo_thr   = {3'h0, lo_field_i, 4'h0} << 1;
    hi_thr   = 11'({2'h0, lo_field_i} + {2'h0, hys_field_i} + 6'h1) << THR_SHIFT;
    floor_v  = quarter_i ? 6'(run_i >> 2) : 6'(run_i >> 1);
    step_v   = 6'h1 << inc_code_i;
    up_v     = {1'b0, scale_o} + step_v;
    case (dec_code_i)
      2'h0:    dec_need = 6'h20;
      2'h1:    dec_need = 6'h08;
      2'h2:    dec_need = 6'h02;
      default: dec_need = 6'h01;
    endcase
  end

  // Regulation; outside its window the run setting is used directly
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      scale_o   <= 5'h1f;
      dec_cnt_q <= 6'h00;
    end else if (!active_i) begin
      scale_o   <= run_i;
      dec_cnt_q <= 6'h00;
    end else if (sample_i) begin
      if ({1'b0, load_i} < lo_thr) begin
        dec_cnt_q <= 6'h00;
        scale_o   <= (up_v > {1'b0, run_i}) ? run_i : up_v[4:0];
      end else if ({1'b0, load_i} >= hi_thr) begin
        if (dec_cnt_q + 6'h1 >= dec_need) begin
          dec_cnt_q <= 6'h00;
          if ({1'b0, scale_o} > floor_v) scale_o <= scale_o - 5'h1;
        end else begin
          dec_cnt_q <= dec_cnt_q + 6'h1;
        end
      end
      if ({1'b0, scale_o} < floor_v) scale_o <= floor_v[4:0];
    end
  end
endmodule : lacs_cur_reg
`default_nettype wire

// ### core/lacs_top.sv
// Load adaptive current regulator with stall halt, top level
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lacs_top
  import lacs_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  // Measurement and ramp inputs
  input  wire logic        full_step_i,
  input  wire logic [9:0]  load_raw_i,
  input  wire logic [22:0] ramp_velocity_i,
  input  wire logic        standstill_i,
  input  wire logic        motion_param_wr_i,
  // Ramp and coil outputs
  output logic             ramp_halt_o,
  output logic             velocity_zero_o,
  output logic [4:0]       coil_scale_o,
  output logic             irq_o
);
  logic [31:0] ctrl_q;
  logic [31:0] cur_q;
  logic [22:0] vlow_q;
  logic [22:0] upper_velocity_threshold_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic        stall_flag_q;
  logic        halt_evt_q;
  logic        params_changed_q;
  logic [7:0]  zwait_q;
  lacs_state_e state_q;
  logic [9:0]  load_v;
  logic        load_vld;
  logic [4:0]  reg_scale;
  logic        win_ok;
  logic        vel_ok;
  logic        reg_active;
  logic        stall_det;
  logic        rd_ramp;

  // Control fields
  wire logic [3:0] lo_field = ctrl_q[CTRL_MIN_LSB +: 4];
  wire logic [4:0] run_cur  = cur_q[CUR_RUN_LSB +: 5];
  wire logic [4:0] hold_cur = cur_q[CUR_HOLD_LSB +: 5];
  wire logic       sd_mode  = ctrl_q[CTRL_SD_BIT];

  // Decode helper shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  lacs_load_filter u_filt (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .step_i     (full_step_i),
    .raw_load_i (load_raw_i),
    .filt_en_i  (ctrl_q[CTRL_FILT_BIT]),
    .load_o     (load_v),
    .load_vld_o (load_vld)
  );

  // Velocity window; step/dir mode has no ramp velocity so limits are skipped
  always_comb begin
    vel_ok     = ramp_velocity_i >= vlow_q;
    win_ok     = sd_mode || (vel_ok && ramp_velocity_i <= upper_velocity_threshold_q);
    reg_active = win_ok && (lo_field != 4'h0) && !standstill_i;
    stall_det  = load_vld && (load_v == 10'h000) && (sd_mode || vel_ok);
    rd_ramp    = reg_rd_i && hit(reg_addr_i, ADDR_RAMP_STAT);
  end

  lacs_cur_reg u_reg (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .active_i    (reg_active),
    .sample_i    (load_vld),
    .load_i      (load_v),
    .lo_field_i  (lo_field),
    .hys_field_i (ctrl_q[CTRL_HYS_LSB +: 4]),
    .inc_code_i  (ctrl_q[CTRL_INC_LSB +: 2]),
    .dec_code_i  (ctrl_q[CTRL_DEC_LSB +: 2]),
    .quarter_i   (ctrl_q[CTRL_LOWER_LOAD_THRESHOLD_BIT]),
    .run_i       (run_cur),
    .scale_o     (reg_scale)
  );

  // Configuration registers
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ctrl_q     <= CTRL_RESET;
      cur_q      <= CUR_RESET;
      vlow_q     <= 23'h00_0000;
      upper_velocity_threshold_q    <= UPPER_VELOCITY_THRESHOLD_RESET;
      irq_mask_q <= 2'h0;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, ADDR_CTRL))     ctrl_q     <= reg_wdata_i;
      if (hit(reg_addr_i, ADDR_CUR))      cur_q      <= reg_wdata_i;
      if (hit(reg_addr_i, ADDR_VLOW))     vlow_q     <= reg_wdata_i[22:0];
      // Zero would disable everything, so it is held at the least value of one
      if (hit(reg_addr_i, ADDR_UPPER_VELOCITY_THRESHOLD))    upper_velocity_threshold_q    <= (reg_wdata_i[22:0] == 23'h0) ? 23'h1 : reg_wdata_i[22:0];
      if (hit(reg_addr_i, ADDR_IRQ_MASK)) irq_mask_q <= reg_wdata_i[1:0];
    end
  end

  // Halt sequencer: set wins over a read clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_q          <= LACS_IDLE;
      halt_evt_q       <= 1'b0;
      stall_flag_q     <= 1'b0;
      params_changed_q <= 1'b0;
      zwait_q          <= 8'h00;
    end else begin
      // Flag holds from one load result to the next so software can read it
      if (load_vld) stall_flag_q <= stall_det;
      case (state_q)
        LACS_IDLE, LACS_RUN: begin
          state_q <= LACS_RUN;
          if (stall_det && ctrl_q[CTRL_HALT_BIT]) begin
            state_q          <= LACS_HALT;
            halt_evt_q       <= 1'b1;
            stall_flag_q     <= 1'b1;
            params_changed_q <= 1'b0;
            zwait_q          <= 8'(ZWAIT_CYC);
          end
        end
        LACS_HALT: begin
          if (motion_param_wr_i) params_changed_q <= 1'b1;
          if (zwait_q != 8'h00) zwait_q <= zwait_q - 8'h1;
          if (rd_ramp) halt_evt_q <= 1'b0;
          // Leaving the halt also when software drops the enable
          if (!ctrl_q[CTRL_HALT_BIT] ||
              (!halt_evt_q && zwait_q == 8'h00 && !params_changed_q)) begin
            state_q <= LACS_RUN;
            halt_evt_q <= 1'b0;
          end
        end
        default: state_q <= LACS_IDLE;
      endcase
    end
  end

  // Interrupt status, write one to clear, set has priority
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      irq_stat_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (reg_wr_i && hit(reg_addr_i, ADDR_IRQ_STAT) && reg_wdata_i[i]) irq_stat_q[i] <= 1'b0;
      end
      if (stall_det && ctrl_q[CTRL_HALT_BIT] && state_q != LACS_HALT) irq_stat_q[IRQ_STALL_BIT] <= 1'b1;
      if (load_vld) irq_stat_q[IRQ_LOAD_BIT] <= 1'b1;
    end
  end

  // Outputs, all registered
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ramp_halt_o     <= 1'b0;
      velocity_zero_o <= 1'b0;
      coil_scale_o    <= 5'h00;
      irq_o           <= 1'b0;
    end else begin
      ramp_halt_o     <= (state_q == LACS_HALT);
      velocity_zero_o <= (state_q == LACS_HALT);
      coil_scale_o    <= reg_active ? reg_scale : (standstill_i ? hold_cur : run_cur);
      irq_o           <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read data, valid in the cycle after the read strobe
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_CTRL:      reg_rdata_o <= ctrl_q;
        ADDR_VLOW:      reg_rdata_o <= {9'h000, vlow_q};
        ADDR_UPPER_VELOCITY_THRESHOLD:     reg_rdata_o <= {9'h000, upper_velocity_threshold_q};
        ADDR_CUR:       reg_rdata_o <= cur_q;
        ADDR_DRV_STAT:  reg_rdata_o <= {7'h00, stall_flag_q, 3'h0, reg_scale, 6'h00, load_v};
        // Halted bit follows the halt output so the two never disagree
        ADDR_RAMP_STAT: reg_rdata_o <= {29'h0, ramp_halt_o, 1'b0, halt_evt_q};
        ADDR_IRQ_STAT:  reg_rdata_o <= {30'h0, irq_stat_q};
        ADDR_IRQ_MASK:  reg_rdata_o <= {30'h0, irq_mask_q};
        default:        reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end
endmodule : lacs_top
`default_nettype wire

// ### testbench/lacs_top_checker.sv
// Port level assertions for the load adaptive current and stall block
`timescale 1ns/1ps
`default_nettype none
module lacs_top_checker
  import lacs_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  // Register port
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Measurement and ramp
  input wire logic        full_step_i,
  input wire logic [9:0]  load_raw_i,
  input wire logic [22:0] ramp_velocity_i,
  input wire logic        standstill_i,
  input wire logic        motion_param_wr_i,
  input wire logic        ramp_halt_o,
  input wire logic        velocity_zero_o,
  input wire logic [4:0]  coil_scale_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic [2:0] quiet_q;

  // Counts calm cycles; the scale has no cause to move once four have passed
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || full_step_i || reg_wr_i || !$stable(ramp_velocity_i) || !$stable(standstill_i)) begin
      quiet_q <= 3'h0;
    end else if (quiet_q != 3'h4) begin
      quiet_q <= quiet_q + 3'h1;
    end
  end

  AST_HALT_PAIR: assert property (ramp_halt_o == velocity_zero_o)
    else $error("halt and zero velocity disagree");
  AST_HALT_CAUSE: assert property ($rose(ramp_halt_o) |-> $past(full_step_i, 3) && $past(load_raw_i, 3) == 10'h0)
    else $error("halt without a zero load step");
  AST_HALT_STICK: assert property ($rose(ramp_halt_o) |=> ramp_halt_o [*8])
    else $error("halt released too early");
  AST_RAMP_HALTED: assert property ($past(reg_rd_i && reg_addr_i == ADDR_RAMP_STAT && ramp_halt_o) |-> reg_rdata_o[2])
    else $error("ramp status misses halted state");
  AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  AST_RD_UNMAP: assert property ($past(reg_rd_i && reg_addr_i == 8'h20) |-> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_IRQ_CLEAR: assert property ($fell(irq_o) |-> $past(reg_wr_i, 2) || $past(reg_wr_i, 3))
    else $error("interrupt dropped without a write");
  AST_SCALE_QUIET: assert property (quiet_q == 3'h4 |-> $stable(coil_scale_o))
    else $error("coil scale moved without a cause");
endmodule // lacs_top_checker
`default_nettype wire

// ### testbench/lacs_top_tb.sv
// Self-checking bench for the load adaptive current and stall block
`timescale 1ns/1ps
`default_nettype none
module lacs_top_tb;
  import lacs_pkg::*;
  logic        core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, full_step_i, standstill_i, motion_param_wr_i;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [9:0]  load_raw_i;
  logic [22:0] ramp_velocity_i;
  logic        ramp_halt_o, velocity_zero_o, irq_o;
  logic        rd_q = 1'b0;
  logic [4:0]  coil_scale_o;
  logic [31:0] exp_q[$], msk_q[$];
  int          fails, check_count, cycles, seed, n, es;
  int          dn[4] = '{32, 8, 2, 1};

  // Core clock
  always #2.5 core_clk_i = ~core_clk_i;

  lacs_top u_lacs_top (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .full_step_i(full_step_i),
    .load_raw_i(load_raw_i), .ramp_velocity_i(ramp_velocity_i), .standstill_i(standstill_i),
    .motion_param_wr_i(motion_param_wr_i), .ramp_halt_o(ramp_halt_o), .velocity_zero_o(velocity_zero_o),
    .coil_scale_o(coil_scale_o), .irq_o(irq_o)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_i);
  endtask

  // Bus tasks hold each strobe for exactly one edge, then idle one cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    cyc(1);
    reg_wr_i <= 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back(e);
    msk_q.push_back(m);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    cyc(1);
    reg_rd_i <= 1'b0;
    cyc(1);
  endtask

  // One full step, then time for the scale to follow
  task automatic step(input logic [9:0] v);
    full_step_i <= 1'b1;
    load_raw_i  <= v;
    cyc(1);
    full_step_i <= 1'b0;
    cyc(4);
  endtask

  task automatic hi(input int k);
    repeat (k) step(10'h3ff);
  endtask

  task automatic chs(input logic [4:0] e);
    check(32'(coil_scale_o), 32'(e));
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] i, input logic [1:0] d, input logic [3:0] f);
    return {16'h0, f, d, i, 8'h12};
  endfunction

  // Read data stands one cycle after its strobe; compare with the oldest note
  always @(posedge core_clk_i) begin
    if (rd_q) check(reg_rdata_o & msk_q.pop_front(), exp_q.pop_front());
    rd_q <= reg_rd_i;
  end

  // Hang guard, far above the roughly 1500 cycles the run needs
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    core_clk_i = 1'b0;
    sys_rst_i = 1'b1;
    {reg_wr_i, reg_rd_i, full_step_i, standstill_i, motion_param_wr_i} = 5'h0;
    reg_addr_i = 8'h0;
    reg_wdata_i = 32'h0;
    load_raw_i = 10'h0;
    ramp_velocity_i = 23'h0;
    seed = 14315;
    cyc(5);
    sys_rst_i <= 1'b0;
    cyc(1);
    rd(ADDR_CTRL, '1, CTRL_RESET);
    rd(ADDR_CUR, '1, CUR_RESET);
    rd(ADDR_UPPER_VELOCITY_THRESHOLD, '1, 32'(UPPER_VELOCITY_THRESHOLD_RESET));
    rd(ADDR_IRQ_MASK, '1, 32'h0);
    rd(8'h20, '1, 32'h0);
    chs(5'h1f);
    $display("reset test done");
    // Run 28 gives exact floors of 14 and 7
    wr(ADDR_VLOW, 32'd100);
    wr(ADDR_UPPER_VELOCITY_THRESHOLD, 32'd1000);
    wr(ADDR_CUR, 32'h101c);
    ramp_velocity_i <= 23'd500;
    wr(ADDR_CTRL, ctl(2'h0, 2'h3, 4'h0));
    hi(40);
    es = 14;
    chs(5'(es));
    rd(ADDR_DRV_STAT, 32'h1f_03ff, 32'h0e_03ff);
    step(10'd63);
    chs(5'h0f);
    step(10'd64);
    step(10'd127);
    chs(5'h0f);
    step(10'd128);
    chs(5'h0e);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, ctl(2'(k), 2'h3, 4'h0));
      step(10'd63);
      es = (es + (1 << k) > 28) ? 28 : es + (1 << k);
      chs(5'(es));
    end
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL, ctl(2'h0, 2'(c), 4'h0));
      step(10'd63);
      es = (es == 28) ? 28 : es + 1;
      hi(dn[c] - 1);
      chs(5'(es));
      hi(1);
      es = es - 1;
      chs(5'(es));
    end
    wr(ADDR_CTRL, ctl(2'h0, 2'h3, 4'h1));
    hi(24);
    chs(5'h07);
    $display("regulation test done");
    ramp_velocity_i <= 23'd99;
    cyc(4);
    chs(5'h1c);
    standstill_i <= 1'b1;
    cyc(4);
    chs(5'h10);
    standstill_i <= 1'b0;
    ramp_velocity_i <= 23'd1001;
    cyc(4);
    chs(5'h1c);
    ramp_velocity_i <= 23'd500;
    wr(ADDR_CTRL, 32'h0);
    cyc(4);
    chs(5'h1c);
    ramp_velocity_i <= 23'd50;
    wr(ADDR_CTRL, ctl(2'h0, 2'h3, 4'h8));
    hi(20);
    chs(5'h0e);
    $display("window test done");
    // Mid band loads leave the scale alone
    ramp_velocity_i <= 23'd500;
    wr(ADDR_CTRL, ctl(2'h0, 2'h3, 4'h0));
    hi(16);
    repeat (4) begin
      n = 64 + ($random(seed) & 63);
      step(10'(n));
      rd(ADDR_DRV_STAT, 32'h3ff, 32'(n));
    end
    chs(5'h0e);
    wr(ADDR_CTRL, ctl(2'h0, 2'h3, 4'h2));
    repeat (2) begin
      step(10'd70);
      step(10'd80);
      step(10'd90);
      step(10'd101);
    end
    rd(ADDR_DRV_STAT, 32'h3ff, 32'd85);
    $display("load test done");
    ramp_velocity_i <= 23'd99;
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_IRQ_STAT, 32'h3);
    wr(ADDR_CTRL, ctl(2'h0, 2'h3, 4'h4));
    step(10'h0);
    check(32'(ramp_halt_o), 32'h0);
    ramp_velocity_i <= 23'd500;
    step(10'h0);
    cyc(2);
    check(32'({ramp_halt_o, velocity_zero_o, irq_o}), 32'h7);
    rd(ADDR_DRV_STAT, 32'h100_0000, 32'h100_0000);
    rd(ADDR_RAMP_STAT, 32'h5, 32'h5);
    rd(ADDR_RAMP_STAT, 32'h1, 32'h0);
    wr(ADDR_IRQ_STAT, 32'h1);
    cyc(2);
    check(32'(irq_o), 32'h0);
    cyc(250);
    check(32'(ramp_halt_o), 32'h0);
    // A motion change while halted blocks the automatic restart
    step(10'h0);
    motion_param_wr_i <= 1'b1;
    cyc(1);
    motion_param_wr_i <= 1'b0;
    rd(ADDR_RAMP_STAT, 32'h1, 32'h1);
    cyc(300);
    check(32'(ramp_halt_o), 32'h1);
    wr(ADDR_CTRL, ctl(2'h0, 2'h3, 4'h0));
    cyc(2);
    check(32'(ramp_halt_o), 32'h0);
    $display("stall test done");
    summarize();
  end
endmodule // lacs_top_tb

bind lacs_top lacs_top_checker u_lacs_top_checker (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .full_step_i(full_step_i),
  .load_raw_i(load_raw_i), .ramp_velocity_i(ramp_velocity_i), .standstill_i(standstill_i),
  .motion_param_wr_i(motion_param_wr_i), .ramp_halt_o(ramp_halt_o), .velocity_zero_o(velocity_zero_o),
  .coil_scale_o(coil_scale_o), .irq_o(irq_o)
);
`default_nettype wire
